// ---- rtl/fms_pkg.sv ----
// Package for the framer master status and interrupt block.
// Assumes a single 50 MHz system clock and an APB register port.
`default_nettype none
package fms_pkg;
  localparam int APB_AW = 12;
  localparam int REG_W = 8;
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_SUMMARY = 8'h06;
  localparam logic [7:0] IDX_RT = 8'h08;
  localparam logic [7:0] IDX_LAT = 8'h09;
  localparam logic [7:0] IDX_IE = 8'h0A;
  localparam logic [7:0] IDX_CTRL = 8'h0B;
  localparam logic [APB_AW-1:0] ADDR_SUMMARY = {2'h0, IDX_SUMMARY, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_RT = {2'h0, IDX_RT, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_LAT = {2'h0, IDX_LAT, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_IE = {2'h0, IDX_IE, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  // Bit positions shared by status, latched and enable registers.
  localparam int BIT_TICK = 0;
  localparam int BIT_OVF = 1;
  localparam int BIT_TESTER = 2;
  localparam int BIT_DL = 3;
  localparam int BIT_FE = 4;
  localparam int BIT_LF = 5;
  localparam int BIT_TXL = 6;
  localparam int BIT_RXL = 7;
  localparam int BIT_CLK_SEL = 0;
  localparam logic [REG_W-1:0] LAT_MASK = 8'hC3;
  localparam logic [REG_W-1:0] IE_RST = 8'h00;
  localparam logic [REG_W-1:0] REG_ZERO = 8'h00;
  // Missing-clock window is 9 to 21 periods; the midpoint is used.
  localparam int LOSS_MIN = 9;
  localparam int LOSS_MAX = 21;
  localparam int LOSS_LIMIT = (LOSS_MIN + LOSS_MAX) / 2;
  localparam int TICK_EDGES_DFLT = 1000000;
endpackage : fms_pkg
`default_nettype wire

// ---- rtl/fms_clk_loss.sv ----
// Missing-clock detector: flags a line clock that stopped toggling.
// Assumes line_clk is sampled as a synchronous input of clk.
`default_nettype none
module fms_clk_loss #(
  parameter int LIMIT = fms_pkg::LOSS_LIMIT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic line_clk,
  output logic loss
);
  import fms_pkg::*;
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(LIMIT);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  logic prev_r;
  logic [CW-1:0] cnt_r;
  logic loss_r;
  logic toggle;

  assign toggle = line_clk != prev_r;
  assign loss = loss_r;

  // Loss starts set after reset and clears on the first toggle seen.
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_r <= 1'b0;
      cnt_r <= CNT_MAX;
      loss_r <= 1'b1;
    end else if (ce) begin
      prev_r <= line_clk;
      if (toggle) begin
        cnt_r <= '0;
        loss_r <= 1'b0;
      end else if (cnt_r != CNT_MAX) begin
        cnt_r <= cnt_r + CNT_ONE;
        loss_r <= (cnt_r + CNT_ONE) == CNT_MAX;
      end
    end
  end

  AST_LOSS_SET: assert property (@(posedge clk) disable iff (reset)
    ce && !toggle && cnt_r == CNT_MAX - CNT_ONE |=> loss_r)
    else $error("clock loss not flagged at limit");
  AST_LOSS_CLR: assert property (@(posedge clk) disable iff (reset)
    ce && toggle |=> !loss_r && cnt_r == '0)
    else $error("clock loss not cleared by toggle");
  AST_LOSS_RST: assert property (@(posedge clk)
    $fell(reset) |-> loss_r)
    else $error("clock loss not set after reset");
  COV_LOSS: cover property (@(posedge clk) disable iff (reset) $rose(loss_r));
endmodule // fms_clk_loss
`default_nettype wire

// ---- rtl/fms_sec_timer.sv ----
// One-second timer counting rising edges of a chosen line clock.
// Assumes both line clocks are sampled as synchronous inputs of clk.
`default_nettype none
module fms_sec_timer #(
  parameter int TICK_EDGES = fms_pkg::TICK_EDGES_DFLT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic rx_clk,
  input wire logic tx_clk,
  input wire logic sel_tx,
  output logic tick
);
  import fms_pkg::*;
  localparam int CW = $clog2(TICK_EDGES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(TICK_EDGES - 1);
  localparam logic [CW-1:0] CNT_ONE = CW'(1);
  logic src;
  logic prev_r;
  logic [CW-1:0] cnt_r;
  logic tick_r;
  logic rise;

  // Select 0 times from the receive clock, 1 from the transmit clock.
  assign src = sel_tx ? tx_clk : rx_clk;
  assign rise = src && !prev_r;
  assign tick = tick_r;

  // The boundary is arbitrary: counting simply starts at reset.
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_r <= 1'b0;
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (ce) begin
      prev_r <= src;
      tick_r <= rise && cnt_r == CNT_LAST;
      if (rise) begin
        cnt_r <= (cnt_r == CNT_LAST) ? '0 : cnt_r + CNT_ONE;
      end
    end
  end

  AST_TICK: assert property (@(posedge clk) disable iff (reset)
    ce && rise && cnt_r == CNT_LAST |=> tick_r && cnt_r == '0)
    else $error("tick missing at boundary");
  COV_TICK: cover property (@(posedge clk) disable iff (reset) tick_r);
endmodule // fms_sec_timer
`default_nettype wire

// ---- rtl/fms_master_status.sv ----
// Master status, latched status and interrupt enable for one framer.
// Assumes APB master, synchronous sampled line clocks, one clock domain.
//
// The implementer's own choice: the APB register port.
`default_nettype none
module fms_master_status #(
  parameter int SUB_W = 8,
  parameter int TICK_EDGES = fms_pkg::TICK_EDGES_DFLT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fms_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic counter_saturated,
  input wire logic [SUB_W-1:0] tester_latched_status,
  input wire logic [SUB_W-1:0] tester_status_enable,
  input wire logic [SUB_W-1:0] datalink_latched_status,
  input wire logic [SUB_W-1:0] datalink_status_enable,
  input wire logic [SUB_W-1:0] farend_latched_status,
  input wire logic [SUB_W-1:0] farend_status_enable,
  input wire logic [SUB_W-1:0] line_framer_latched_status,
  input wire logic [SUB_W-1:0] line_framer_status_enable,
  input wire logic tx_input_clock,
  input wire logic rx_line_clock,
  output logic framer_irq
);
  import fms_pkg::*;

  logic [REG_W-1:0] rt_r;
  logic [REG_W-1:0] rt_nxt;
  logic [REG_W-1:0] lat_r;
  logic [REG_W-1:0] lat_nxt;
  logic [REG_W-1:0] lat_set;
  logic [REG_W-1:0] ie_r;
  logic [REG_W-1:0] pend;
  logic one_second_clock_select;
  logic framer_irq_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [REG_W-1:0] rd_val;
  logic addr_ok;
  logic setup;
  logic wr_en;
  logic wr_lat;
  logic tx_clock_loss;
  logic rx_clock_loss;
  logic tick;

  // Missing-clock detectors, one per line clock.
  fms_clk_loss #(
    .LIMIT(LOSS_LIMIT)
  ) u_tx_loss (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .line_clk(tx_input_clock),
    .loss(tx_clock_loss)
  );

  fms_clk_loss #(
    .LIMIT(LOSS_LIMIT)
  ) u_rx_loss (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .line_clk(rx_line_clock),
    .loss(rx_clock_loss)
  );

  // One-second boundary generator.
  fms_sec_timer #(
    .TICK_EDGES(TICK_EDGES)
  ) u_timer (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .rx_clk(rx_line_clock),
    .tx_clk(tx_input_clock),
    .sel_tx(one_second_clock_select),
    .tick(tick)
  );

  // Real-time status is rebuilt every cycle from its live sources.
  always_comb begin
    rt_nxt = REG_ZERO;
    rt_nxt[BIT_OVF] = counter_saturated;
    rt_nxt[BIT_TESTER] = |(tester_latched_status & tester_status_enable);
    rt_nxt[BIT_DL] = |(datalink_latched_status & datalink_status_enable);
    rt_nxt[BIT_FE] = |(farend_latched_status & farend_status_enable);
    rt_nxt[BIT_LF] = |(line_framer_latched_status & line_framer_status_enable);
    rt_nxt[BIT_TXL] = tx_clock_loss;
    rt_nxt[BIT_RXL] = rx_clock_loss;
  end

  // Loss bits leave reset high, as the detectors do, so no false rising edge is latched.
  always_ff @(posedge clk) begin
    if (reset) begin
      rt_r <= REG_ZERO;
      rt_r[BIT_TXL] <= 1'b1;
      rt_r[BIT_RXL] <= 1'b1;
    end else if (ce) begin
      rt_r <= rt_nxt;
    end
  end

  // APB decode; the slave answers in the first access cycle.
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_r && pwrite;
  assign wr_lat = wr_en && paddr == ADDR_LAT;

  always_comb begin
    addr_ok = 1'b1;
    rd_val = REG_ZERO;
    unique case (paddr)
      ADDR_SUMMARY: rd_val = {7'h00, framer_irq_r};
      ADDR_RT: rd_val = rt_r;
      ADDR_LAT: rd_val = lat_r;
      ADDR_IE: rd_val = ie_r;
      ADDR_CTRL: rd_val = {7'h00, one_second_clock_select};
      default: addr_ok = 1'b0;
    endcase
  end

  // Ready and data are registered in the setup cycle, so no wait states.
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (ce) begin
      pready_r <= setup;
      pslverr_r <= setup && !addr_ok;
      if (setup && !pwrite) begin
        prdata_r <= {24'h000000, rd_val};
      end
    end
  end

  // Latched flags: rising edges and the tick set; host writes one to clear.
  // A set arriving with a clear wins, so no event is lost.
  always_comb begin
    lat_set = REG_ZERO;
    lat_set[BIT_TICK] = tick;
    lat_set[BIT_OVF] = rt_nxt[BIT_OVF] && !rt_r[BIT_OVF];
    lat_set[BIT_TXL] = rt_nxt[BIT_TXL] && !rt_r[BIT_TXL];
    lat_set[BIT_RXL] = rt_nxt[BIT_RXL] && !rt_r[BIT_RXL];
    lat_nxt = lat_r;
    if (wr_lat) begin
      lat_nxt = lat_r & ~pwdata[REG_W-1:0];
    end
    lat_nxt = (lat_nxt | lat_set) & LAT_MASK;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lat_r <= REG_ZERO;
    end else if (ce) begin
      lat_r <= lat_nxt;
    end
  end

  // Enable and control registers are plain read-write.
  always_ff @(posedge clk) begin
    if (reset) begin
      ie_r <= IE_RST;
      one_second_clock_select <= 1'b0;
    end else if (ce && wr_en) begin
      if (paddr == ADDR_IE) begin
        ie_r <= pwdata[REG_W-1:0];
      end
      if (paddr == ADDR_CTRL) begin
        one_second_clock_select <= pwdata[BIT_CLK_SEL];
      end
    end
  end

  // Change bits come from real-time status, the rest from latched flags.
  always_comb begin
    pend = lat_r;
    pend[BIT_TESTER] = rt_r[BIT_TESTER];
    pend[BIT_DL] = rt_r[BIT_DL];
    pend[BIT_FE] = rt_r[BIT_FE];
    pend[BIT_LF] = rt_r[BIT_LF];
    pend = pend & ie_r;
  end

  // The request is registered so the pin never glitches on decode.
  always_ff @(posedge clk) begin
    if (reset) begin
      framer_irq_r <= 1'b0;
    end else if (ce) begin
      framer_irq_r <= |pend;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign framer_irq = framer_irq_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_OVF_RT: assert property (
    ce |=> rt_r[BIT_OVF] == $past(counter_saturated))
    else $error("overflow status does not follow saturation");
  AST_TESTER_CHG: assert property (
    ce |=> rt_r[BIT_TESTER] == $past(|(tester_latched_status & tester_status_enable)))
    else $error("tester change bit wrong");
  AST_DL_CHG: assert property (
    ce |=> rt_r[BIT_DL] == $past(|(datalink_latched_status & datalink_status_enable)))
    else $error("data-link change bit wrong");
  AST_FE_CHG: assert property (
    ce |=> rt_r[BIT_FE] == $past(|(farend_latched_status & farend_status_enable)))
    else $error("far-end change bit wrong");
  AST_LF_CHG: assert property (
    ce |=> rt_r[BIT_LF] == $past(|(line_framer_latched_status & line_framer_status_enable)))
    else $error("line framer change bit wrong");
  AST_CHG_IRQ: assert property (
    ce && rt_r[BIT_TESTER] && ie_r[BIT_TESTER] |=> framer_irq_r)
    else $error("enabled change bit did not raise interrupt");
  AST_IRQ_OR: assert property (
    ce && pend == REG_ZERO |=> !framer_irq_r)
    else $error("interrupt without enabled source");
  AST_TICK_LAT: assert property (
    ce && tick |=> lat_r[BIT_TICK])
    else $error("tick flag not latched");
  AST_TICK_W1C: assert property (
    ce && wr_lat && pwdata[BIT_TICK] && !tick |=> !lat_r[BIT_TICK])
    else $error("tick flag not cleared by write one");
  AST_OVF_LAT: assert property (
    ce && counter_saturated && !rt_r[BIT_OVF] |=> lat_r[BIT_OVF])
    else $error("overflow edge not latched");
  AST_TXL_LAT: assert property (
    ce && $rose(tx_clock_loss) |=> lat_r[BIT_TXL])
    else $error("transmit loss edge not latched");
  AST_RXL_LAT: assert property (
    ce && $rose(rx_clock_loss) |=> lat_r[BIT_RXL])
    else $error("receive loss edge not latched");
  AST_LAT_IRQ: assert property (
    ce && lat_r[BIT_OVF] && ie_r[BIT_OVF] |=> framer_irq_r)
    else $error("enabled latched flag did not raise interrupt");
  AST_IE_RST: assert property (
    $fell(reset) |-> ie_r == IE_RST)
    else $error("enables not zero after reset");
  AST_PREADY: assert property (
    ce && setup |=> pready_r ##1 (!pready_r || !ce))
    else $error("ready not given in first access cycle");

  COV_IRQ: cover property ($rose(framer_irq_r));
  COV_W1C: cover property (wr_lat && lat_r != REG_ZERO);
  COV_ERR: cover property (pslverr_r);
endmodule // fms_master_status
`default_nettype wire

// ---- tb/fms_host_model.sv ----
// APB host model standing in for the processor that services the framer.
// Assumes its task is entered just after a rising clk edge.
`default_nettype none
module fms_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [fms_pkg::APB_AW-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  import fms_pkg::*;

  // The bus is idle from time zero.
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = '0;
    pwdata = 32'h0;
  end

  // One transfer; the request holds until pready is sampled high.
  // An idle edge follows, so back to back calls never collide in one step.
  task automatic xfer(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
endmodule // fms_host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the framer master status block.
// Assumes the host model drives APB and the bench drives all status inputs.
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fms_pkg::*;
  logic clk, reset, sat, txc, rxc, tx_run, rx_run, framer_irq;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0] lat [4];
  logic [7:0] en [4];
  int errors, cmp_count, cycles;

  fms_master_status #(.SUB_W(8), .TICK_EDGES(8)) i_fms_master_status (
    .clk(clk), .reset(reset), .ce(1'h1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .counter_saturated(sat),
    .tester_latched_status(lat[0]), .tester_status_enable(en[0]),
    .datalink_latched_status(lat[1]), .datalink_status_enable(en[1]),
    .farend_latched_status(lat[2]), .farend_status_enable(en[2]),
    .line_framer_latched_status(lat[3]), .line_framer_status_enable(en[3]),
    .tx_input_clock(txc), .rx_line_clock(rxc), .framer_irq(framer_irq));

  fms_host_model i_fms_host_model (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // System clock, 20 ns period.
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // Line clocks toggle every cycle while running; stopping one models a lost clock.
  always @(posedge clk) begin
    if (tx_run) txc <= ~txc;
    if (rx_run) rxc <= ~rxc;
  end

  // Hang guard; the tests need well under a thousand cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
    i_fms_host_model.xfer(1'h1, a, d, rdat, err);
  endtask

  // Reads a register and compares the masked low byte.
  task automatic rchk(input string nm, input logic [APB_AW-1:0] a, input logic [7:0] m,
                      input logic [7:0] ex);
    i_fms_host_model.xfer(1'h0, a, 32'h0, rdat, err);
    `CHK(nm, ex, rdat[7:0] & m)
  endtask

  // Main sequence; clocks stay stopped through reset to see the loss bits.
  initial begin
    logic [7:0] m;
    reset = 1'h1;
    sat = 1'h0;
    txc = 1'h0;
    rxc = 1'h0;
    tx_run = 1'h0;
    rx_run = 1'h0;
    errors = 0;
    cmp_count = 0;
    cycles = 0;
    for (int i = 0; i < 4; i++) begin
      lat[i] = 8'h00;
      en[i] = 8'h00;
    end
    cyc(12);
    reset <= 1'h0;
    cyc(1);
    rchk("loss at reset", ADDR_RT, 8'hC0, 8'hC0);
    rchk("ie reset", ADDR_IE, 8'hFF, 8'h00);
    tx_run <= 1'h1;
    rx_run <= 1'h1;
    cyc(4);
    rchk("loss cleared", ADDR_RT, 8'hC0, 8'h00);
    rchk("no loss latch at reset", ADDR_LAT, 8'hC0, 8'h00);
    wr(ADDR_RT, 32'hFF);
    rchk("rt read only", ADDR_RT, 8'hFE, 8'h00);
    i_fms_host_model.xfer(1'h0, 12'h3C, 32'h0, rdat, err);
    `CHK("unmapped", 1'h1, err)
    for (int i = 0; i < 4; i++) begin
      m = 8'h04 << i;
      lat[i] <= 8'h10;
      en[i] <= 8'h20;
      cyc(3);
      rchk("change unmatched", ADDR_RT, m, 8'h00);
      en[i] <= 8'h30;
      cyc(3);
      rchk("change", ADDR_RT, m, m);
      `CHK("irq masked", 1'h0, framer_irq)
      wr(ADDR_IE, {24'h0, m});
      cyc(3);
      `CHK("irq", 1'h1, framer_irq)
      rchk("summary", ADDR_SUMMARY, 8'h01, 8'h01);
      wr(ADDR_IE, 32'h0);
      cyc(3);
      `CHK("irq en off", 1'h0, framer_irq)
      lat[i] <= 8'h00;
      cyc(3);
      rchk("change cleared", ADDR_RT, m, 8'h00);
      en[i] <= 8'h00;
    end
    sat <= 1'h1;
    cyc(3);
    rchk("ovf rt", ADDR_RT, 8'h02, 8'h02);
    rchk("ovf lat", ADDR_LAT, 8'h02, 8'h02);
    wr(ADDR_IE, 32'h02);
    cyc(3);
    `CHK("ovf irq", 1'h1, framer_irq)
    wr(ADDR_LAT, 32'h02);
    cyc(3);
    `CHK("ovf irq off", 1'h0, framer_irq)
    rchk("ovf lat held", ADDR_LAT, 8'h02, 8'h00);
    sat <= 1'h0;
    cyc(3);
    rchk("ovf rt clear", ADDR_RT, 8'h02, 8'h00);
    sat <= 1'h1;
    cyc(3);
    rchk("ovf relatch", ADDR_LAT, 8'h02, 8'h02);
    sat <= 1'h0;
    for (int k = 0; k < 2; k++) begin
      m = 8'h40 << k;
      wr(ADDR_IE, {24'h0, m});
      wr(ADDR_LAT, 32'hFF);
      if (k == 0) tx_run <= 1'h0;
      else rx_run <= 1'h0;
      cyc(5);
      rchk("loss early", ADDR_RT, m, 8'h00);
      cyc(14);
      rchk("loss set", ADDR_RT, m, m);
      rchk("loss lat", ADDR_LAT, m, m);
      `CHK("loss irq", 1'h1, framer_irq)
      wr(ADDR_LAT, {24'h0, m});
      rchk("loss lat held", ADDR_LAT, m, 8'h00);
      tx_run <= 1'h1;
      rx_run <= 1'h1;
      cyc(3);
      rchk("loss gone", ADDR_RT, m, 8'h00);
    end
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_CTRL, s);
      rchk("clk sel", ADDR_CTRL, 8'h01, s[7:0]);
      wr(ADDR_IE, 32'h01);
      if (s == 0) rx_run <= 1'h0;
      else tx_run <= 1'h0;
      cyc(2);
      wr(ADDR_LAT, 32'h01);
      cyc(40);
      rchk("tick idle", ADDR_LAT, 8'h01, 8'h00);
      `CHK("tick irq off", 1'h0, framer_irq)
      tx_run <= 1'h1;
      rx_run <= 1'h1;
      cyc(40);
      rchk("tick", ADDR_LAT, 8'h01, 8'h01);
      `CHK("tick irq", 1'h1, framer_irq)
    end
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
